// [design/sli_top.sv]
// status indicator and safety interlock top level
`timescale 1ns/10ps

// Overview of operation
// - power indicator only if supply within 24V +/-2V
// - same check on internal module output
// - emission indicator on nonzero request or degas
// - emission off on zero request or fault
// - multiplier indicator exactly while bias applied
// - bias off: zero request, degas, overpressure
// - degas indicator throughout degas process
// - activity indicator from usb, lan, rs232 traffic
// - link error indicator on interface errors
// - pressure indicator when emission unreachable
// - overpressure kills emission, multiplier; lights error, leak
// - system error on any operational error
// - grounded permit input kills emission and bias
// - trigger starts scan only when armed
// - rs232 fixed 28800 baud 8N1
// - rs232 dce with rts/cts flow control
// - one general purpose bit, in or out
module sli_top
  import sli_pkg::*;
#(
  parameter int unsigned HOLD_CYC = ACT_HOLD_CYC
)(
  // clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_rst_b,
  // supply monitor
  input  wire logic [15:0]     i_supply_mv,
  input  wire logic            i_int_supply,
  // firmware control and status bits
  input  wire sli_pkg::sli_ctl_t  i_ctl,
  input  wire sli_pkg::sli_link_t i_link_act,
  input  wire sli_pkg::sli_link_t i_link_err,
  input  wire logic            i_scan_arm,
  // external pins
  input  wire logic            i_high_voltage_permit,
  input  wire logic            i_scan_trigger_input,
  // general purpose bit
  input  wire logic            i_gpio_in,
  output logic                 o_gpio_out,
  output logic                 o_gpio_oe_b,
  input  wire logic            i_gpio_dir_out,
  input  wire logic            i_gpio_wdata,
  output logic                 o_gpio_rdata,
  // rs232 pins, device is dce
  input  wire logic            i_rs232_rxd,
  output logic                 o_rs232_txd,
  input  wire logic            i_rs232_rts,
  output logic                 o_rs232_cts,
  // rs232 byte side
  input  wire logic [7:0]      i_tx_data,
  input  wire logic            i_tx_valid,
  output logic                 o_tx_ready,
  output logic [7:0]           o_rx_data,
  output logic                 o_rx_valid,
  input  wire logic            i_rx_ready,
  // outputs
  output logic                 o_emission_en,
  output logic                 o_multiplier_en,
  output logic                 o_scan_start,
  output logic                 o_leak_indicator,
  output sli_pkg::sli_led_t    o_led
);
  import sli_pkg::*;

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] permit_s_q;
  logic [SYNC_STAGES-1:0] scan_trigger_input_s_q;
  logic [SYNC_STAGES-1:0] gpio_s_q;
  logic [SYNC_STAGES-1:0] rxd_s_q;
  logic [SYNC_STAGES-1:0] rts_s_q;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      permit_s_q <= '0;
      scan_trigger_input_s_q   <= '0;
      gpio_s_q   <= '0;
      rxd_s_q    <= '1;
      rts_s_q    <= '0;
    end
    else
    begin
      permit_s_q <= {permit_s_q[0], i_high_voltage_permit};
      scan_trigger_input_s_q   <= {scan_trigger_input_s_q[0], i_scan_trigger_input};
      gpio_s_q   <= {gpio_s_q[0], i_gpio_in};
      rxd_s_q    <= {rxd_s_q[0], i_rs232_rxd};
      rts_s_q    <= {rts_s_q[0], i_rs232_rts};
    end
  end

  // permit pulled to ground acts as a level, low blocks high voltage
  wire permit_ok = permit_s_q[1];
  wire scan_trigger_input_sync = scan_trigger_input_s_q[1];
  wire rts_ok    = rts_s_q[1];

  // ---------------------------------------------------------------
  // supply check, run once after reset release
  // ---------------------------------------------------------------
  sli_pwr_st_t pwr_st_q;
  sli_pwr_st_t pwr_st_d;
  // internal module output is presented on the same monitor input
  wire supply_in_range = (i_supply_mv >= SUPPLY_MIN_MV)
                      && (i_supply_mv <= SUPPLY_MAX_MV);

  always_comb
  begin
    pwr_st_d = pwr_st_q;
    unique case (pwr_st_q)
      SLI_PWR_IDLE:  pwr_st_d = SLI_PWR_CHECK;
      SLI_PWR_CHECK: pwr_st_d = supply_in_range ? SLI_PWR_OK : SLI_PWR_FAIL;
      SLI_PWR_OK:    pwr_st_d = SLI_PWR_OK;
      SLI_PWR_FAIL:  pwr_st_d = SLI_PWR_FAIL;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pwr_st_q <= SLI_PWR_IDLE;
    else
      pwr_st_q <= pwr_st_d;
  end

  wire power_good = (pwr_st_q == SLI_PWR_OK);
  wire power_fail = (pwr_st_q == SLI_PWR_FAIL);

  // ---------------------------------------------------------------
  // interlocks
  // ---------------------------------------------------------------
  // overpressure is latched so a brief excursion still leaves emission off
  logic overpress_q;
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      overpress_q <= 1'b0;
    else if (i_ctl.overpress)
      overpress_q <= 1'b1;
    else if (!i_ctl.emis_req)
      overpress_q <= 1'b0;
  end

  wire ovp_any  = i_ctl.overpress || overpress_q;
  wire fil_trip = ovp_any || i_ctl.worn_fil;
  wire emis_d   = (i_ctl.emis_req || i_ctl.degas_run)
                  && !fil_trip && permit_ok;
  wire mult_d   = i_ctl.bias_req && !i_ctl.degas_run
                  && !ovp_any && permit_ok;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_emission_en   <= 1'b0;
      o_multiplier_en <= 1'b0;
    end
    else
    begin
      o_emission_en   <= emis_d;
      o_multiplier_en <= mult_d;
    end
  end

  // ---------------------------------------------------------------
  // scan trigger
  // ---------------------------------------------------------------
  logic scan_trigger_input_d1_q;
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      scan_trigger_input_d1_q    <= 1'b0;
      o_scan_start <= 1'b0;
    end
    else
    begin
      scan_trigger_input_d1_q    <= scan_trigger_input_sync;
      o_scan_start <= scan_trigger_input_sync && !scan_trigger_input_d1_q && i_scan_arm;
    end
  end

  // ---------------------------------------------------------------
  // general purpose bit, enable low while driving
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_gpio_out   <= 1'b0;
      o_gpio_oe_b  <= 1'b1;
      o_gpio_rdata <= 1'b0;
    end
    else
    begin
      o_gpio_out   <= i_gpio_wdata;
      o_gpio_oe_b  <= !i_gpio_dir_out;
      o_gpio_rdata <= gpio_s_q[1];
    end
  end

  // ---------------------------------------------------------------
  // rs232 link
  // ---------------------------------------------------------------
  logic       uart_rx_valid;
  logic       uart_rx_err;
  logic [7:0] uart_rx_data;
  logic       uart_tx_ready;
  logic       uart_txd;

  // host may send only while cts is high; cts follows our ready to take
  assign o_rs232_cts = i_rx_ready;
  assign o_tx_ready  = uart_tx_ready;
  assign o_rs232_txd = uart_txd;
  assign o_rx_data   = uart_rx_data;
  assign o_rx_valid  = uart_rx_valid;

  sli_uart #(
    .DIV (BAUD_DIV)
  ) u_uart (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_rxd       (rxd_s_q[1]),
    .o_txd       (uart_txd),
    .i_tx_permit (rts_ok),
    .i_tx_data   (i_tx_data),
    .i_tx_valid  (i_tx_valid),
    .o_tx_ready  (uart_tx_ready),
    .o_rx_data   (uart_rx_data),
    .o_rx_valid  (uart_rx_valid),
    .o_rx_err    (uart_rx_err)
  );

  // ---------------------------------------------------------------
  // link activity and error stretchers
  // ---------------------------------------------------------------
  // stretch short events so the indicator is visible to the eye
  wire act_evt = i_link_act.usb || i_link_act.lan || i_link_act.rs232
              || uart_rx_valid || (i_tx_valid && uart_tx_ready);
  wire err_evt = i_link_err.usb || i_link_err.lan || i_link_err.rs232
              || uart_rx_err;
  logic [31:0] act_cnt_q;
  logic [31:0] err_cnt_q;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      act_cnt_q <= 32'h0000_0000;
      err_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      act_cnt_q <= act_evt ? 32'(HOLD_CYC)
                 : (act_cnt_q != 32'h0 ? act_cnt_q - 32'h1 : 32'h0);
      err_cnt_q <= err_evt ? 32'(HOLD_CYC)
                 : (err_cnt_q != 32'h0 ? err_cnt_q - 32'h1 : 32'h0);
    end
  end

  // ---------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------
  wire sys_err_d = power_fail || ovp_any || i_ctl.hw_err || i_ctl.probe_err
                || (err_cnt_q != 32'h0) || i_ctl.worn_fil;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_led            <= sli_led_t'(LED_RST);
      o_leak_indicator <= 1'b0;
    end
    else
    begin
      o_led.power      <= power_good;
      o_led.emission   <= emis_d;
      o_led.multiplier <= mult_d;
      o_led.degas      <= i_ctl.degas_run;
      o_led.link_act   <= (act_cnt_q != 32'h0) || act_evt;
      o_led.link_err   <= (err_cnt_q != 32'h0) || err_evt;
      o_led.pressure   <= i_ctl.no_emis_reg || ovp_any
                          || i_ctl.worn_fil;
      o_led.sys_err    <= sys_err_d;
      o_leak_indicator <= ovp_any;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_ovp_seen;
    i_ctl.overpress;
  endsequence

  sequence s_scan_trigger_input_rise;
    scan_trigger_input_sync && !scan_trigger_input_d1_q;
  endsequence

  AST_MULT_TRACKS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_led.multiplier |-> ($past(i_ctl.bias_req) && !$past(i_ctl.degas_run)))
    else $error("multiplier indicator lit without a bias request");

  AST_OVP_KILL: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s_ovp_seen |=> (!o_emission_en && !o_multiplier_en && o_leak_indicator
                    && o_led.sys_err))
    else $error("overpressure did not shut down emission and bias");

  AST_PERMIT_LOW: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_high_voltage_permit [*3] |=> (!o_emission_en && !o_multiplier_en))
    else $error("high voltage active while permit grounded");

  AST_SCAN_TRIGGER_INPUT_ARMED: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_scan_start |-> $past(i_scan_arm))
    else $error("scan started while not armed");

  AST_SCAN_TRIGGER_INPUT_START: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s_scan_trigger_input_rise and i_scan_arm) |=> o_scan_start)
    else $error("armed trigger edge did not start scan");

  AST_DEGAS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_ctl.degas_run |=> (o_led.degas && !o_multiplier_en))
    else $error("degas indicator or bias wrong during degas");

  AST_EMIS_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!i_ctl.emis_req && !i_ctl.degas_run) |=> !o_emission_en)
    else $error("emission on without request");

  AST_PWR_CHECK: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (pwr_st_q == SLI_PWR_CHECK && !supply_in_range) |=> ##1
      (!o_led.power && o_led.sys_err))
    else $error("out of range supply did not raise error");

  AST_ACT_STRETCH: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    act_evt |=> o_led.link_act [*2])
    else $error("activity indicator not held after traffic");

  // an idle line must stay high while the host withholds rts
  AST_CTS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!u_uart.tx_busy_q && !rts_ok) |=> o_rs232_txd)
    else $error("transmit started without rts");

endmodule

// [design/sli_pkg.sv]
// package of constants and carrier types for the status and interlock block
package sli_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned RS232_BAUD    = 28_800;
  localparam int unsigned BAUD_DIV      = (CLK_HZ + RS232_BAUD / 2) / RS232_BAUD;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned ACT_HOLD_MS   = 50;
  localparam int unsigned ACT_HOLD_CYC  = (CLK_HZ / 1000) * ACT_HOLD_MS;
  localparam int unsigned SYNC_STAGES   = 2;

  // ---------------------------------------------------------------
  // supply range in millivolts, 24 V plus or minus 2 V
  // ---------------------------------------------------------------
  localparam logic [15:0] SUPPLY_MIN_MV = 16'd22000;
  localparam logic [15:0] SUPPLY_MAX_MV = 16'd26000;

  // ---------------------------------------------------------------
  // indicator bit positions
  // ---------------------------------------------------------------
  localparam int unsigned LED_POWER = 0;
  localparam int unsigned LED_EMIS  = 1;
  localparam int unsigned LED_MULT  = 2;
  localparam int unsigned LED_DEGAS = 3;
  localparam int unsigned LED_LACT  = 4;
  localparam int unsigned LED_LERR  = 5;
  localparam int unsigned LED_PRESS = 6;
  localparam int unsigned LED_SYS   = 7;
  localparam logic [7:0]  LED_RST   = 8'h00;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic power;
    logic emission;
    logic multiplier;
    logic degas;
    logic link_act;
    logic link_err;
    logic pressure;
    logic sys_err;
  } sli_led_t;

  typedef struct packed {
    logic emis_req;
    logic bias_req;
    logic degas_run;
    logic worn_fil;
    logic overpress;
    logic no_emis_reg;
    logic hw_err;
    logic probe_err;
  } sli_ctl_t;

  typedef struct packed {
    logic usb;
    logic lan;
    logic rs232;
  } sli_link_t;

  typedef enum logic [1:0] {
    SLI_PWR_IDLE,
    SLI_PWR_CHECK,
    SLI_PWR_OK,
    SLI_PWR_FAIL
  } sli_pwr_st_t;

endpackage

// [design/sli_uart.sv]
// rs232 byte transceiver, 8 data bits, no parity, one stop bit, rts/cts paced
`timescale 1ns/10ps
module sli_uart
  import sli_pkg::*;
#(
  parameter int unsigned DIV = BAUD_DIV
)(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  // serial pins, already synchronised
  input  wire logic       i_rxd,
  output logic            o_txd,
  input  wire logic       i_tx_permit,
  // byte side
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_err
);

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  logic        tx_busy_q;
  wire         tx_tick  = (tx_cnt_q == 16'(DIV - 1));
  wire         tx_start = i_tx_valid && !tx_busy_q && i_tx_permit;

  assign o_tx_ready = !tx_busy_q && i_tx_permit;
  assign o_txd      = tx_sh_q[0];

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3ff;
      tx_busy_q <= 1'b0;
    end
    else if (tx_start)
    begin
      tx_sh_q   <= {1'b1, i_tx_data, 1'b0};
      tx_busy_q <= 1'b1;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
    end
    else if (tx_busy_q)
    begin
      tx_cnt_q <= tx_tick ? 16'h0000 : tx_cnt_q + 16'h0001;
      if (tx_tick)
      begin
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == 4'h9)
          tx_busy_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // receiver, samples mid bit
  // ---------------------------------------------------------------
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_busy_q;
  wire         rx_tick = (rx_cnt_q == 16'(DIV - 1));
  wire         rx_half = (rx_cnt_q == 16'(DIV / 2));

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_cnt_q   <= 16'h0000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_busy_q  <= 1'b0;
      o_rx_data  <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_err   <= 1'b0;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      o_rx_err   <= 1'b0;
      if (!rx_busy_q)
      begin
        rx_cnt_q <= 16'h0000;
        rx_bit_q <= 4'h0;
        if (!i_rxd)
          rx_busy_q <= 1'b1;
      end
      else
      begin
        rx_cnt_q <= rx_tick ? 16'h0000 : rx_cnt_q + 16'h0001;
        if (rx_half)
        begin
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && i_rxd)
            rx_busy_q <= 1'b0;
          else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8)
            rx_sh_q <= {i_rxd, rx_sh_q[7:1]};
          else if (rx_bit_q == 4'h9)
          begin
            rx_busy_q  <= 1'b0;
            o_rx_data  <= rx_sh_q;
            o_rx_valid <= i_rxd;
            o_rx_err   <= !i_rxd;
          end
        end
      end
    end
  end

endmodule

// [tb/sli_host_model.sv]
// host side model of the rs232 link, 8n1 framing with rts/cts pacing
`timescale 1ns/10ps
module sli_host_model
#(
  parameter int DIV = 3472
)(
  // clock
  input  wire logic i_mclk,
  // serial pins seen from the host
  input  wire logic i_txd,
  input  wire logic i_cts,
  output logic      o_rxd,
  output logic      o_rts
);
  initial
  begin
    o_rxd = 1'b1;
    o_rts = 1'b0;
  end

  task automatic set_rts(input logic v);
    @(posedge i_mclk);
    o_rts <= v;
  endtask

  // frame is start, eight bits lsb first, stop; held off until cts is high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (i_cts !== 1'b1)
      @(posedge i_mclk);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge i_mclk);
      o_rxd <= f[i];
      repeat (DIV - 1) @(posedge i_mclk);
    end
  endtask

  // samples each bit near its middle
  task automatic get_byte(output logic [7:0] b, output logic stop);
    @(negedge i_txd);
    repeat (DIV / 2) @(posedge i_mclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (DIV) @(posedge i_mclk);
      b[i] = i_txd;
    end
    repeat (DIV) @(posedge i_mclk);
    stop = i_txd;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the status and interlock block
`timescale 1ns/10ps
module tb;
  import sli_pkg::*;
  localparam int HOLD = 8;
  logic i_mclk = 1'b0, i_rst_b = 1'b0;
  logic [15:0] i_supply_mv = 16'h5dc0;
  sli_ctl_t i_ctl = '0;
  sli_link_t i_link_act = '0, i_link_err = '0;
  logic i_scan_arm = 1'b0, i_high_voltage_permit = 1'b1, i_scan_trigger_input = 1'b0;
  logic i_gpio_in = 1'b0, i_gpio_dir_out = 1'b0, i_gpio_wdata = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  logic i_tx_valid = 1'b0, i_rx_ready = 1'b0;
  logic [15:0] sup [4] = '{16'h55ef, 16'h55f0, 16'h6591, 16'h6590};
  logic o_gpio_out, o_gpio_oe_b, o_gpio_rdata, rxd, o_rs232_txd, rts, o_rs232_cts;
  logic o_tx_ready, o_rx_valid, o_emission_en, o_multiplier_en, o_scan_start, o_leak_indicator;
  logic [7:0] o_rx_data;
  sli_led_t o_led, e;
  int n_mismatch = 0, samples_checked = 0, cnt;
  logic [31:0] r = 32'h2a0ae0d5;
  logic latch, ok, stop;
  logic [7:0] b;

  always #5 i_mclk = ~i_mclk;

  sli_top #(.HOLD_CYC(HOLD)) sli_top_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_supply_mv(i_supply_mv), .i_int_supply(1'b1), .i_ctl(i_ctl), .i_link_act(i_link_act),
    .i_link_err(i_link_err), .i_scan_arm(i_scan_arm),
    .i_high_voltage_permit(i_high_voltage_permit), .i_scan_trigger_input(i_scan_trigger_input),
    .i_gpio_in(i_gpio_in), .o_gpio_out(o_gpio_out), .o_gpio_oe_b(o_gpio_oe_b),
    .i_gpio_dir_out(i_gpio_dir_out), .i_gpio_wdata(i_gpio_wdata), .o_gpio_rdata(o_gpio_rdata),
    .i_rs232_rxd(rxd), .o_rs232_txd(o_rs232_txd), .i_rs232_rts(rts), .o_rs232_cts(o_rs232_cts),
    .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
    .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .o_emission_en(o_emission_en), .o_multiplier_en(o_multiplier_en),
    .o_scan_start(o_scan_start), .o_leak_indicator(o_leak_indicator), .o_led(o_led));

  sli_host_model #(.DIV(BAUD_DIV)) sli_host_model_i (.i_mclk(i_mclk), .i_txd(o_rs232_txd),
    .i_cts(o_rs232_cts), .o_rxd(rxd), .o_rts(rts));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // a run longer than two serial frames plus margin means a hang
  initial
  begin
    repeat (100000) @(posedge i_mclk);
    n_mismatch++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    // supply window edges, each after its own reset
    foreach (sup[i])
    begin
      @(posedge i_mclk);
      i_rst_b <= 1'b0;
      i_supply_mv <= sup[i];
      cyc(3);
      @(posedge i_mclk);
      i_rst_b <= 1'b1;
      cyc(8);
      ok = (i_supply_mv >= SUPPLY_MIN_MV) && (i_supply_mv <= SUPPLY_MAX_MV);
      chk("power", {6'h0, o_led.power, o_led.sys_err}, {6'h0, ok, !ok});
    end
    // random control and permit levels against the interlock model
    latch = 1'b0;
    repeat (60)
    begin
      r = lfsr(r);
      @(posedge i_mclk);
      i_ctl <= r[7:0];
      i_high_voltage_permit <= r[8] | r[9];
      i_gpio_dir_out <= r[10];
      i_gpio_wdata <= r[11];
      i_gpio_in <= r[12];
      cyc(6);
      latch = i_ctl.overpress | (latch & i_ctl.emis_req);
      e = '0;
      e.power = 1'b1;
      e.emission = (i_ctl.emis_req | i_ctl.degas_run) & !i_ctl.worn_fil & !latch
                   & i_high_voltage_permit;
      e.multiplier = i_ctl.bias_req & !i_ctl.degas_run & !latch & i_high_voltage_permit;
      e.degas = i_ctl.degas_run;
      e.pressure = i_ctl.no_emis_reg | latch | i_ctl.worn_fil;
      e.sys_err = latch | i_ctl.worn_fil | i_ctl.hw_err | i_ctl.probe_err;
      chk("leds", o_led, e);
      chk("hv", {5'h0, o_emission_en, o_multiplier_en, o_leak_indicator},
          {5'h0, e.emission, e.multiplier, latch});
      chk("gpio", {5'h0, o_gpio_out, o_gpio_oe_b, o_gpio_rdata},
          {5'h0, i_gpio_wdata, !i_gpio_dir_out, i_gpio_in});
    end
    @(posedge i_mclk);
    i_ctl <= '0;
    i_high_voltage_permit <= 1'b1;
    cyc(4);
    // each link's activity and error are stretched, then drop
    for (int k = 0; k < 3; k++)
    begin
      @(posedge i_mclk);
      i_link_act <= sli_link_t'(3'h1 << k);
      i_link_err <= sli_link_t'(3'h1 << k);
      @(posedge i_mclk);
      i_link_act <= '0;
      i_link_err <= '0;
      cyc(2);
      chk("link", {5'h0, o_led.link_act, o_led.link_err, o_led.sys_err}, 8'h07);
      cyc(HOLD + 4);
      chk("link_end", {5'h0, o_led.link_act, o_led.link_err, o_led.sys_err}, 8'h00);
    end
    // trigger ignored while disarmed, one pulse when armed
    for (int a = 0; a < 2; a++)
    begin
      @(posedge i_mclk);
      i_scan_arm <= a[0];
      cyc(2);
      @(posedge i_mclk);
      i_scan_trigger_input <= 1'b1;
      cnt = 0;
      repeat (8)
      begin
        cyc(1);
        cnt += int'(o_scan_start);
      end
      @(posedge i_mclk);
      i_scan_trigger_input <= 1'b0;
      chk("scan", 8'(cnt), 8'(a));
    end
    // general purpose bit as output then as input
    @(posedge i_mclk);
    i_gpio_dir_out <= 1'b1;
    i_gpio_wdata <= 1'b1;
    cyc(4);
    chk("gpio_out", {6'h0, o_gpio_out, o_gpio_oe_b}, 8'h02);
    @(posedge i_mclk);
    i_gpio_dir_out <= 1'b0;
    i_gpio_in <= 1'b1;
    cyc(5);
    chk("gpio_in", {6'h0, o_gpio_rdata, o_gpio_oe_b}, 8'h03);
    // transmit refused while the host holds rts low
    @(posedge i_mclk);
    i_tx_data <= 8'h3c;
    i_tx_valid <= 1'b1;
    cyc(10);
    chk("tx_ready", {6'h0, o_tx_ready, o_rs232_cts}, 8'h00);
    @(posedge i_mclk);
    i_rx_ready <= 1'b1;
    fork
      sli_host_model_i.send_byte(8'ha5);
      begin
        do @(negedge i_mclk); while (o_rx_valid !== 1'b1);
        chk("rx_data", o_rx_data, 8'ha5);
      end
      begin
        sli_host_model_i.get_byte(b, stop);
        chk("tx_data", b, 8'h3c);
        chk("tx_stop", {7'h0, stop}, 8'h01);
      end
      begin
        sli_host_model_i.set_rts(1'b1);
        do @(negedge i_mclk); while (o_tx_ready !== 1'b1);
        @(posedge i_mclk);
        i_tx_valid <= 1'b0;
      end
    join
    complete_run();
  end
endmodule
